//--- rtl/sixrs_supervisor.sv
// Six-rail enable, power-good and fault supervisor top level
// Overview of operation
// RULE1 - Each rail follows its enable; one shared enable drives rails three and four.
// RULE2 - Enabled rail within 7% of target raises its power-good.
// RULE3 - Deviation beyond 10% drops power-good until back within 7%.
// RULE4 - Combined power-good is high only when rails three to six are good.
// RULE5 - Power-good high means good; open-drain pulled low otherwise.
// RULE6 - Supply undervoltage turns all switch drives off, non-latched.
// RULE7 - Input overvoltage turns all switch drives off, non-latched.
// RULE8 - Overtemperature turns all switch drives off, non-latched.
// RULE9 - Short timer counts while any rail output is low from short or overload.
// RULE10 - Low for 1.4 ms latches short fault and stops all drives.
// RULE11 - All enables low clears short latch; rails restart when re-enabled.
// RULE12 - Supply undervoltage then recovery also clears the short latch.
// RULE13 - Any output above 120% turns switch drives off, non-latched.
// RULE14 - During output overvoltage rail four keeps low-side on, high-side off.
// RULE15 - Output overvoltage shutdown releases below 103% of target.
// RULE16 - Rail four frequency select: high 700 kHz, low 350 kHz; others 700 kHz.
// RULE17 - Host keeps rail four at 700 kHz unless 0.75 V regulates poorly.
// RULE18 - Shared select high gives 1.8/0.9 V for rails three/four, low 1.5/0.75 V.
// RULE19 - Rail six select high gives 1.1 V, low gives 1.05 V.
// RULE20 - Both ramp selects low give a 1.4 ms ramp.
// RULE21 - Enable rise ramps reference up; fall ramps it down to zero.
// RULE22 - Two three-level ramp selects choose nine ramp times, 1.4 to 8.2 ms.
// RULE23 - Current limit is per rail but its output drop trips the short latch.
// RULE24 - Global shutdown overrides enables and forces power-good low.
// RULE25 - Short timer clears whenever no rail reports a low output.
`timescale 1ns/10ps
module sixrs_supervisor (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  // Rail enables
  input  wire logic        I_RAIL1_ENABLE,
  input  wire logic        I_RAIL2_ENABLE,
  input  wire logic        I_RAIL34_SHARED_ENABLE,
  input  wire logic        I_RAIL5_ENABLE,
  input  wire logic        I_RAIL6_ENABLE,
  // Preset selects and ramp straps
  input  wire logic        I_RAIL34_VOLTAGE_SELECT,
  input  wire logic        I_RAIL6_VOLTAGE_SELECT,
  input  wire logic        I_RAIL4_FREQUENCY_SELECT,
  input  wire logic [1:0]  I_RAMP_TIME_SELECT_A,
  input  wire logic [1:0]  I_RAMP_TIME_SELECT_B,
  // Supply and temperature comparators
  input  wire logic        I_SUPPLY_UNDERVOLTAGE,
  input  wire logic        I_INPUT_OVERVOLTAGE,
  input  wire logic        I_OVER_TEMPERATURE,
  // Per-rail output comparators, bit n is rail n+1
  input  wire logic [5:0]  I_RAIL_WITHIN_7,
  input  wire logic [5:0]  I_RAIL_OUTSIDE_10,
  input  wire logic [5:0]  I_RAIL_ABOVE_120,
  input  wire logic [5:0]  I_RAIL_BELOW_103,
  input  wire logic [5:0]  I_RAIL_OUTPUT_LOW,
  // Switch drives
  output logic [5:0]       O_HIGH_SIDE_ON,
  output logic [5:0]       O_LOW_SIDE_ON,
  // Power-good open-drain pins, enable low means pin pulled low
  output logic [5:0]       O_RAIL_POWER_GOOD,
  output logic [5:0]       O_RAIL_POWER_GOOD_OE_N,
  output logic             O_COMBINED_POWER_GOOD,
  output logic             O_COMBINED_POWER_GOOD_OE_N,
  // Presets and status
  output logic [1:0]       O_RAIL34_TARGET_HIGH,
  output logic             O_RAIL6_TARGET_HIGH,
  output logic             O_RAIL4_SLOW_CLOCK,
  output logic [5:0]       O_RAIL_PWM_CLOCK,
  output logic [47:0]      O_RAMP_LEVEL,
  output logic             O_SHORT_CIRCUIT_LATCH,
  output logic             O_OUTPUT_OVERVOLTAGE_GUARD,
  output logic             O_GLOBAL_SHUTDOWN
);
  // Synchronised pins
  logic [5:0]  en_s;
  logic [5:0]  sel_s;
  logic [3:0]  strap_s;
  logic [2:0]  flt_s;
  logic [5:0]  w7_s;
  logic [5:0]  o10_s;
  logic [5:0]  a120_s;
  logic [5:0]  b103_s;
  logic [5:0]  low_s;

  sixrs_sync #(.W(6)) u_sync_en (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   ({I_RAIL6_ENABLE, I_RAIL5_ENABLE, I_RAIL34_SHARED_ENABLE,
                 I_RAIL34_SHARED_ENABLE, I_RAIL2_ENABLE, I_RAIL1_ENABLE}),  // see RULE1
    .o_sync    (en_s)
  );
  sixrs_sync #(.W(6)) u_sync_sel (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   ({3'h0, I_RAIL34_VOLTAGE_SELECT, I_RAIL6_VOLTAGE_SELECT,
                 I_RAIL4_FREQUENCY_SELECT}),
    .o_sync    (sel_s)
  );
  sixrs_sync #(.W(4)) u_sync_strap (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   ({I_RAMP_TIME_SELECT_A, I_RAMP_TIME_SELECT_B}),
    .o_sync    (strap_s)
  );
  sixrs_sync #(.W(3)) u_sync_flt (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   ({I_OVER_TEMPERATURE, I_INPUT_OVERVOLTAGE, I_SUPPLY_UNDERVOLTAGE}),
    .o_sync    (flt_s)
  );
  sixrs_sync #(.W(30)) u_sync_cmp (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .i_async   ({I_RAIL_WITHIN_7, I_RAIL_OUTSIDE_10, I_RAIL_ABOVE_120,
                 I_RAIL_BELOW_103, I_RAIL_OUTPUT_LOW}),
    .o_sync    ({w7_s, o10_s, a120_s, b103_s, low_s})
  );

  wire supply_undervoltage_lockout = flt_s[0];
  wire input_overvoltage_guard = flt_s[1];
  wire otp = flt_s[2];
  wire fsel_fast = sel_s[0];
  wire sel6_high = sel_s[1];
  wire sel34_high = sel_s[2];

  // Fault state
  logic                              short_latch;
  logic                              ovp_active;
  logic                              supply_undervoltage_lockout_prev;
  logic [sixrs_pkg::SHORT_CNT_W-1:0] short_cnt;
  // Non-latched supply and thermal guards track their comparators directly
  wire supply_fault = supply_undervoltage_lockout || input_overvoltage_guard || otp;  // see RULE6 see RULE7 see RULE8
  wire all_off = supply_fault || short_latch;
  wire global_off = all_off || ovp_active;  // see RULE24
  wire any_low = |low_s;  // see RULE23
  wire all_enables_low = (en_s == 6'h00);
  wire supply_undervoltage_lockout_recovered = supply_undervoltage_lockout_prev && !supply_undervoltage_lockout;
  wire short_clear = all_enables_low || supply_undervoltage_lockout_recovered;  // see RULE11 see RULE12
  wire short_hit = (short_cnt == sixrs_pkg::SHORT_CNT_W'(sixrs_pkg::SHORT_CYCLES - 1));
  wire ovp_set = |a120_s;  // see RULE13
  wire ovp_release = (b103_s == 6'h3f);  // see RULE15

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      short_cnt <= '0;
    end else if (!any_low || short_latch) begin
      short_cnt <= '0;  // see RULE25
    end else if (!short_hit) begin
      short_cnt <= short_cnt + 1'b1;  // see RULE9
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      short_latch <= 1'b0;
      supply_undervoltage_lockout_prev   <= 1'b0;
      ovp_active  <= 1'b0;
    end else begin
      supply_undervoltage_lockout_prev <= supply_undervoltage_lockout;
      // Fresh trip wins over a simultaneous clear
      if (any_low && short_hit)
        short_latch <= 1'b1;  // see RULE10
      else if (short_clear)
        short_latch <= 1'b0;
      if (ovp_set)
        ovp_active <= 1'b1;
      else if (ovp_release)
        ovp_active <= 1'b0;
    end
  end

  // Ramp tick: ramp time / steps, chosen by the two three-level straps
  wire [1:0] sa = (strap_s[3:2] > sixrs_pkg::STRAP_HIGH) ? sixrs_pkg::STRAP_HIGH : strap_s[3:2];
  wire [1:0] sb = (strap_s[1:0] > sixrs_pkg::STRAP_HIGH) ? sixrs_pkg::STRAP_HIGH : strap_s[1:0];
  wire [3:0] ramp_idx = 4'(3 * sa + sb);  // see RULE22 see RULE20
  localparam int RAMP_DIV_BITS = sixrs_pkg::RAMP_DIV_W;
  logic [RAMP_DIV_BITS-1:0] ramp_div;
  wire [RAMP_DIV_BITS-1:0] ramp_limit = RAMP_DIV_BITS'(
    sixrs_pkg::RAMP_US[ramp_idx] * sixrs_pkg::CLK_MHZ / sixrs_pkg::RAMP_STEPS - 1);
  wire ramp_tick = (ramp_div >= ramp_limit);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST)
      ramp_div <= '0;
    else if (ramp_tick)
      ramp_div <= '0;
    else
      ramp_div <= ramp_div + 1'b1;
  end

  // Rails
  logic [5:0]                  pg_raw;
  sixrs_pkg::sixrs_rail_e      rail_state [6];
  genvar g;
  generate
    for (g = 0; g < sixrs_pkg::NUM_RAILS; g++) begin : g_rail
      sixrs_rail u_rail (
        .I_CLK        (I_CLK),
        .I_SYS_RST    (I_SYS_RST),
        .i_enable     (en_s[g] && !all_off),
        .i_ramp_tick  (ramp_tick),
        .i_shutdown   (global_off),
        .i_within_7   (w7_s[g]),
        .i_outside_10 (o10_s[g]),
        .o_power_good (pg_raw[g]),
        .o_ramp_level (O_RAMP_LEVEL[g*8 +: 8]),
        .o_state      (rail_state[g])
      );
    end
  endgenerate

  // Switching clocks: rail four may run at half rate
  logic [sixrs_pkg::PWM_W-1:0] fast_cnt;
  logic [sixrs_pkg::PWM_W-1:0] slow_cnt;
  localparam logic [sixrs_pkg::PWM_W-1:0] FAST_LAST = sixrs_pkg::PWM_W'(sixrs_pkg::FAST_PERIOD - 1);
  localparam logic [sixrs_pkg::PWM_W-1:0] SLOW_LAST = sixrs_pkg::PWM_W'(sixrs_pkg::SLOW_PERIOD - 1);
  wire fast_half = (fast_cnt < sixrs_pkg::PWM_W'(sixrs_pkg::FAST_PERIOD / 2));
  wire slow_half = (slow_cnt < sixrs_pkg::PWM_W'(sixrs_pkg::SLOW_PERIOD / 2));
  wire rail4_clk = fsel_fast ? fast_half : slow_half;  // see RULE16

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      fast_cnt <= '0;
      slow_cnt <= '0;
    end else begin
      fast_cnt <= (fast_cnt == FAST_LAST) ? '0 : fast_cnt + 1'b1;
      slow_cnt <= (slow_cnt == SLOW_LAST) ? '0 : slow_cnt + 1'b1;
    end
  end

  // Drive decisions
  wire [5:0] rail_run;
  generate
    for (g = 0; g < sixrs_pkg::NUM_RAILS; g++) begin : g_run
      assign rail_run[g] = (rail_state[g] != sixrs_pkg::RAIL_OFF);
    end
  endgenerate
  wire [5:0] next_hs = (all_off || ovp_active) ? 6'h00 : rail_run;
  wire [5:0] next_ls_base = (all_off || ovp_active) ? 6'h00 : rail_run;
  // Rail four pulls its output down through the low side on overvoltage
  wire [5:0] next_ls = (!all_off && ovp_active) ? 6'h08 : next_ls_base;  // see RULE14
  wire [5:0] next_pg = global_off ? 6'h00 : pg_raw;  // see RULE24
  wire next_all_pg = &next_pg[5:2];  // see RULE4

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_HIGH_SIDE_ON             <= 6'h00;
      O_LOW_SIDE_ON              <= 6'h00;
      O_RAIL_POWER_GOOD          <= sixrs_pkg::PG_RESET;
      O_RAIL_POWER_GOOD_OE_N     <= 6'h00;
      O_COMBINED_POWER_GOOD      <= 1'b0;
      O_COMBINED_POWER_GOOD_OE_N <= 1'b0;
      O_RAIL34_TARGET_HIGH       <= 2'h0;
      O_RAIL6_TARGET_HIGH        <= 1'b0;
      O_RAIL4_SLOW_CLOCK         <= 1'b0;
      O_RAIL_PWM_CLOCK           <= 6'h00;
      O_SHORT_CIRCUIT_LATCH      <= 1'b0;
      O_OUTPUT_OVERVOLTAGE_GUARD <= 1'b0;
      O_GLOBAL_SHUTDOWN          <= 1'b0;
    end else begin
      O_HIGH_SIDE_ON             <= next_hs;  // see RULE6 see RULE10 see RULE13
      O_LOW_SIDE_ON              <= next_ls;
      O_RAIL_POWER_GOOD          <= 6'h00;  // see RULE5
      O_RAIL_POWER_GOOD_OE_N     <= next_pg;
      O_COMBINED_POWER_GOOD      <= 1'b0;
      O_COMBINED_POWER_GOOD_OE_N <= next_all_pg;
      O_RAIL34_TARGET_HIGH       <= {sel34_high, sel34_high};  // see RULE18
      O_RAIL6_TARGET_HIGH        <= sel6_high;  // see RULE19
      O_RAIL4_SLOW_CLOCK         <= !fsel_fast;
      O_RAIL_PWM_CLOCK           <= {fast_half, fast_half, rail4_clk,
                                     fast_half, fast_half, fast_half};
      O_SHORT_CIRCUIT_LATCH      <= short_latch;
      O_OUTPUT_OVERVOLTAGE_GUARD <= ovp_active;
      O_GLOBAL_SHUTDOWN          <= global_off;
    end
  end
endmodule : sixrs_supervisor

//--- shared/sixrs_pkg.sv
// Constants, types and timing figures of the six-rail supervisor
package sixrs_pkg;
  localparam int NUM_RAILS = 6;
  // Clock and short-circuit timing
  localparam int CLK_MHZ = 100;
  localparam int SHORT_TIME_US = 1400;
  localparam int SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;
  localparam int SHORT_CNT_W = 18;
  // Ramp durations in microseconds, index = 3*a + b
  localparam int RAMP_US [9] = '{1400, 2200, 2900, 3500, 4100, 5100, 5900, 7300, 8200};
  localparam int RAMP_NOM_US = 1400;
  localparam int RAMP_STEPS = 256;
  localparam int RAMP_W = 8;
  localparam int RAMP_DIV_W = 12;
  // Switching periods in cycles: 700 kHz and 350 kHz
  localparam int FAST_KHZ = 700;
  localparam int SLOW_KHZ = 350;
  localparam int FAST_PERIOD = (CLK_MHZ * 1000) / FAST_KHZ;
  localparam int SLOW_PERIOD = (CLK_MHZ * 1000) / SLOW_KHZ;
  localparam int PWM_W = 9;
  // Strap level encoding for the ramp selects
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  // Reset values
  localparam logic [5:0] PG_RESET = 6'h00;
  // Rail ramp states
  typedef enum logic [1:0] {RAIL_OFF, RAIL_UP, RAIL_ON, RAIL_DOWN} sixrs_rail_e;
endpackage : sixrs_pkg

//--- rtl/sixrs_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sixrs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         I_CLK,
  input  wire logic         I_SYS_RST,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : sixrs_sync

//--- rtl/sixrs_rail.sv
// One rail: soft ramp state, ramp level and power-good window
`timescale 1ns/10ps
module sixrs_rail (
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  // Control
  input  wire logic                          i_enable,
  input  wire logic                          i_ramp_tick,
  input  wire logic                          i_shutdown,
  // Analog comparator status
  input  wire logic                          i_within_7,
  input  wire logic                          i_outside_10,
  // Status
  output logic                               o_power_good,
  output logic [sixrs_pkg::RAMP_W-1:0]       o_ramp_level,
  output sixrs_pkg::sixrs_rail_e             o_state
);
  localparam logic [sixrs_pkg::RAMP_W-1:0] TOP = '1;
  sixrs_pkg::sixrs_rail_e next_state;
  wire at_top = (o_ramp_level == TOP);
  wire at_zero = (o_ramp_level == '0);
  wire active = (o_state != sixrs_pkg::RAIL_OFF) && !i_shutdown;
  // Ramp direction follows enable
  always_comb begin
    next_state = o_state;
    case (o_state)
      sixrs_pkg::RAIL_OFF:  if (i_enable) next_state = sixrs_pkg::RAIL_UP;
      sixrs_pkg::RAIL_UP:   if (!i_enable) next_state = sixrs_pkg::RAIL_DOWN;
                            else if (at_top) next_state = sixrs_pkg::RAIL_ON;
      sixrs_pkg::RAIL_ON:   if (!i_enable) next_state = sixrs_pkg::RAIL_DOWN;
      sixrs_pkg::RAIL_DOWN: if (i_enable) next_state = sixrs_pkg::RAIL_UP;
                            else if (at_zero) next_state = sixrs_pkg::RAIL_OFF;
      default:              next_state = sixrs_pkg::RAIL_OFF;
    endcase
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_state      <= sixrs_pkg::RAIL_OFF;
      o_ramp_level <= '0;
      o_power_good <= 1'b0;
    end else begin
      o_state <= next_state;  // see RULE21
      if (i_ramp_tick && o_state == sixrs_pkg::RAIL_UP && !at_top)
        o_ramp_level <= o_ramp_level + 1'b1;
      else if (i_ramp_tick && o_state == sixrs_pkg::RAIL_DOWN && !at_zero)
        o_ramp_level <= o_ramp_level - 1'b1;
      // Hysteretic window: set inside 7%, clear outside 10%
      if (!i_enable || !active)
        o_power_good <= 1'b0;  // see RULE24
      else if (i_outside_10)
        o_power_good <= 1'b0;  // see RULE3
      else if (i_within_7)
        o_power_good <= 1'b1;  // see RULE2
    end
  end
endmodule : sixrs_rail

//--- verification/sixrs_host_model.sv
// Host controller model: drives enables and the rail four frequency select, reads power-good pins
`timescale 1ns/10ps
module sixrs_host_model (
  // Clock
  input  wire logic       I_CLK,
  // Bench requests
  input  wire logic [4:0] i_want_en,
  input  wire logic       i_poor_reg,
  // Pins toward the supervisor
  output logic [4:0]      o_enable,
  output logic            o_freq_select,
  input  wire logic [5:0] i_pg,
  input  wire logic [5:0] i_pg_oe_n,
  input  wire logic       i_all_pg,
  input  wire logic       i_all_pg_oe_n,
  // Resolved pin levels
  output logic [5:0]      o_pg_pin,
  output logic            o_all_pin
);
  initial begin
    o_enable = 5'h00;
    o_freq_select = 1'b1;
  end
  always @(posedge I_CLK) begin
    o_enable <= i_want_en;
    o_freq_select <= !i_poor_reg;
  end
  // Pull-up resistor lifts a released pin
  assign o_pg_pin = i_pg_oe_n | i_pg;
  assign o_all_pin = i_all_pg_oe_n | i_all_pg;
endmodule : sixrs_host_model

//--- verification/sixrs_supervisor_properties.sv
// Port assertions for the six-rail supervisor
`timescale 1ns/10ps
module sixrs_supervisor_checker (
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_SYS_RST,
  // Watched inputs
  input wire logic       I_SUPPLY_UNDERVOLTAGE,
  input wire logic       I_INPUT_OVERVOLTAGE,
  input wire logic       I_OVER_TEMPERATURE,
  input wire logic [5:0] I_RAIL_WITHIN_7,
  input wire logic [5:0] I_RAIL_OUTSIDE_10,
  input wire logic [5:0] I_RAIL_ABOVE_120,
  input wire logic [5:0] I_RAIL_BELOW_103,
  input wire logic [5:0] I_RAIL_OUTPUT_LOW,
  // Watched outputs
  input wire logic [5:0] O_HIGH_SIDE_ON,
  input wire logic [5:0] O_LOW_SIDE_ON,
  input wire logic [5:0] O_RAIL_POWER_GOOD,
  input wire logic [5:0] O_RAIL_POWER_GOOD_OE_N,
  input wire logic       O_COMBINED_POWER_GOOD,
  input wire logic       O_COMBINED_POWER_GOOD_OE_N,
  input wire logic       O_SHORT_CIRCUIT_LATCH,
  input wire logic       O_OUTPUT_OVERVOLTAGE_GUARD,
  input wire logic       O_GLOBAL_SHUTDOWN
);
  localparam int SHORT_MIN = 139990;
  logic [17:0] low_run;
  logic        supply_bad;
  logic        good_3_6;
  logic        w7_0;
  assign supply_bad = I_SUPPLY_UNDERVOLTAGE | I_INPUT_OVERVOLTAGE | I_OVER_TEMPERATURE;
  assign good_3_6 = &O_RAIL_POWER_GOOD_OE_N[5:2];
  assign w7_0 = I_RAIL_WITHIN_7[0];
  // Unbroken cycles with some rail output low
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || I_RAIL_OUTPUT_LOW == 6'h00) begin
      low_run <= 18'h0_0000;
    end else if (low_run != 18'h3_FFFF) begin
      low_run <= low_run + 18'h0_0001;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_ovp_held;
    (!(&I_RAIL_BELOW_103))[*5] ##0 O_OUTPUT_OVERVOLTAGE_GUARD;
  endsequence
  sequence s_good_cause;
    $past(w7_0, 2) || $past(w7_0, 3) || $past(w7_0, 4);
  endsequence
  AST_SUPPLY_OFF: assert property (supply_bad[*5] |-> (O_HIGH_SIDE_ON | O_LOW_SIDE_ON) == 6'h00)
    else $error("Drives on during supply fault");
  AST_SHORT_OFF: assert property (O_SHORT_CIRCUIT_LATCH[*2] |-> (O_HIGH_SIDE_ON | O_LOW_SIDE_ON) == 6'h00)
    else $error("Drives on with short latched");
  AST_SHORT_TIME: assert property ($rose(O_SHORT_CIRCUIT_LATCH) |-> low_run >= SHORT_MIN)
    else $error("Short latch set too early");
  AST_OVP_SET: assert property ((|I_RAIL_ABOVE_120)[*5] |-> O_OUTPUT_OVERVOLTAGE_GUARD)
    else $error("Overvoltage guard not set");
  AST_OVP_HOLD: assert property (s_ovp_held |=> O_OUTPUT_OVERVOLTAGE_GUARD)
    else $error("Overvoltage guard released early");
  AST_OVP_HS: assert property (O_OUTPUT_OVERVOLTAGE_GUARD[*2] |-> O_HIGH_SIDE_ON == 6'h00)
    else $error("High side on during overvoltage");
  AST_SHUT_PG: assert property (O_GLOBAL_SHUTDOWN[*3] |-> !(|O_RAIL_POWER_GOOD_OE_N))
    else $error("Power-good released in shutdown");
  AST_ALL_PG: assert property (O_COMBINED_POWER_GOOD_OE_N |-> good_3_6 || $past(good_3_6))
    else $error("Combined good without rails three to six");
  AST_ALL_PG_SET: assert property (good_3_6[*3] |-> O_COMBINED_POWER_GOOD_OE_N)
    else $error("Combined good missing");
  AST_OPEN_DRAIN: assert property (O_RAIL_POWER_GOOD == 6'h00 && !O_COMBINED_POWER_GOOD)
    else $error("Open-drain data not low");
  AST_PG_DROP: assert property (I_RAIL_OUTSIDE_10[0][*5] |-> !O_RAIL_POWER_GOOD_OE_N[0])
    else $error("Power-good kept outside window");
  AST_PG_RISE: assert property ($rose(O_RAIL_POWER_GOOD_OE_N[0]) |-> s_good_cause)
    else $error("Power-good rose outside window");
endmodule : sixrs_supervisor_checker

bind sixrs_supervisor sixrs_supervisor_checker i_sixrs_supervisor_checker (
  .I_CLK, .I_SYS_RST, .I_SUPPLY_UNDERVOLTAGE, .I_INPUT_OVERVOLTAGE, .I_OVER_TEMPERATURE,
  .I_RAIL_WITHIN_7, .I_RAIL_OUTSIDE_10, .I_RAIL_ABOVE_120, .I_RAIL_BELOW_103,
  .I_RAIL_OUTPUT_LOW, .O_HIGH_SIDE_ON, .O_LOW_SIDE_ON, .O_RAIL_POWER_GOOD,
  .O_RAIL_POWER_GOOD_OE_N, .O_COMBINED_POWER_GOOD, .O_COMBINED_POWER_GOOD_OE_N,
  .O_SHORT_CIRCUIT_LATCH, .O_OUTPUT_OVERVOLTAGE_GUARD, .O_GLOBAL_SHUTDOWN
);

//--- verification/test_sixrs_supervisor.sv
// Self-checking testbench for the six-rail supervisor
`timescale 1ns/10ps
module test_sixrs_supervisor;
  logic        I_CLK, I_SYS_RST, poor, all_pin, fsel, rail34_voltage_select, vsel6, uv, ov, ot;
  logic [4:0]  want, en;
  logic [5:0]  w7, o10, a120, b103, olow, hs, ls, pgd, pg_oe_n, pg_pin;
  logic        all_d, all_oe_n, t6, slow, short_circuit_latch, output_overvoltage_guard, shut;
  logic [1:0]  t34, sa, sb;
  logic [5:0]  pwm;
  logic [7:0]  v;
  logic [47:0] ramp;
  int          err_total, n_checks, n, i;
  logic [4:0]  en_tab [4] = '{5'h04, 5'h05, 5'h0D, 5'h1F};
  logic [5:0]  dr_tab [4] = '{6'h0C, 6'h0D, 6'h1D, 6'h3F};
  logic [5:0]  o10_tab [4] = '{6'h01, 6'h10, 6'h00, 6'h00};
  logic [5:0]  w7_tab [4] = '{6'h3E, 6'h2F, 6'h2F, 6'h3F};
  logic        all_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  sixrs_host_model i_sixrs_host_model (.I_CLK, .i_want_en(want), .i_poor_reg(poor),
    .o_enable(en), .o_freq_select(fsel), .i_pg(pgd), .i_pg_oe_n(pg_oe_n), .i_all_pg(all_d),
    .i_all_pg_oe_n(all_oe_n), .o_pg_pin(pg_pin), .o_all_pin(all_pin));
  sixrs_supervisor i_sixrs_supervisor (.I_CLK, .I_SYS_RST, .I_RAIL1_ENABLE(en[0]),
    .I_RAIL2_ENABLE(en[1]), .I_RAIL34_SHARED_ENABLE(en[2]), .I_RAIL5_ENABLE(en[3]),
    .I_RAIL6_ENABLE(en[4]), .I_RAIL34_VOLTAGE_SELECT(rail34_voltage_select), .I_RAIL6_VOLTAGE_SELECT(vsel6),
    .I_RAIL4_FREQUENCY_SELECT(fsel), .I_RAMP_TIME_SELECT_A(sa), .I_RAMP_TIME_SELECT_B(sb),
    .I_SUPPLY_UNDERVOLTAGE(uv), .I_INPUT_OVERVOLTAGE(ov), .I_OVER_TEMPERATURE(ot),
    .I_RAIL_WITHIN_7(w7), .I_RAIL_OUTSIDE_10(o10), .I_RAIL_ABOVE_120(a120),
    .I_RAIL_BELOW_103(b103), .I_RAIL_OUTPUT_LOW(olow), .O_HIGH_SIDE_ON(hs),
    .O_LOW_SIDE_ON(ls), .O_RAIL_POWER_GOOD(pgd), .O_RAIL_POWER_GOOD_OE_N(pg_oe_n),
    .O_COMBINED_POWER_GOOD(all_d), .O_COMBINED_POWER_GOOD_OE_N(all_oe_n),
    .O_RAIL34_TARGET_HIGH(t34), .O_RAIL6_TARGET_HIGH(t6), .O_RAIL4_SLOW_CLOCK(slow),
    .O_RAIL_PWM_CLOCK(pwm), .O_RAMP_LEVEL(ramp), .O_SHORT_CIRCUIT_LATCH(short_circuit_latch),
    .O_OUTPUT_OVERVOLTAGE_GUARD(output_overvoltage_guard), .O_GLOBAL_SHUTDOWN(shut));

  always #5 I_CLK = !I_CLK;

  task automatic tick(input int c);
    repeat (c) @(posedge I_CLK);
  endtask : tick

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    {I_CLK, poor, rail34_voltage_select, vsel6, uv, ov, ot, err_total, n_checks} = '0;
    {want, a120, olow, sa, sb} = '0;
    I_SYS_RST = 1'b1;
    {w7, b103, o10} = {6'h3F, 6'h3F, 6'h00};
    tick(6);
    I_SYS_RST <= 1'b0;
    tick(1);
    check("rst_drive", {hs, ls}, 0);
    check("rst_pg", {all_pin, pg_pin}, 0);
    for (i = 0; i < 2; i++) begin
      {rail34_voltage_select, vsel6, poor} <= {i[0], i[0], !i[0]};
      tick(8);
      check("t34", t34, {2{i[0]}});
      check("t6", t6, i[0]);
      check("slow", slow, !i[0]);
      // Measure one high half of the rail four switching clock
      n = 0;
      while (pwm[3] && n < 900) begin
        tick(1);
        n++;
      end
      while (!pwm[3] && n < 900) begin
        tick(1);
        n++;
      end
      n = 0;
      while (pwm[3] && n < 900) begin
        tick(1);
        n++;
      end
      check("pwm4_half", n, i[0] ? sixrs_pkg::FAST_PERIOD / 2 : sixrs_pkg::SLOW_PERIOD / 2);
      check("pwm1_fast", pwm[0], pwm[1]);
    end
    $display("test presets done");
    for (i = 0; i < 4; i++) begin
      want <= en_tab[i];
      tick(8);
      check("hs_map", hs, dr_tab[i]);
      check("ls_map", ls, dr_tab[i]);
    end
    check("pg_on", {all_pin, pg_pin}, 7'h7F);
    for (i = 0; i < 4; i++) begin
      {o10, w7} <= {o10_tab[i], w7_tab[i]};
      tick(8);
      check("pg_pin", pg_pin, w7_tab[i]);
      check("all_pg", all_pin, all_tab[i]);
    end
    tick(600);
    check("ramp_up", ramp[7:0] != 8'h00, 1);
    $display("test enables done");
    for (i = 0; i < 3; i++) begin
      {ot, ov, uv} <= 3'h1 << i;
      tick(8);
      check("flt_drive", {hs, ls}, 0);
      check("flt_pg", {shut, all_pin, pg_pin}, 8'h80);
      {ot, ov, uv} <= 3'h0;
      n = 0;
      while (hs !== 6'h3F && n < 1000) begin
        tick(1);
        n++;
      end
      check("flt_free", n < 1000, 1);
    end
    $display("test faults done");
    {a120, b103} <= {6'h01, 6'h3E};
    tick(8);
    check("ovp_drive", {output_overvoltage_guard, hs, ls}, 13'h1008);
    a120 <= 6'h00;
    tick(8);
    check("ovp_hold", output_overvoltage_guard, 1);
    b103 <= 6'h3F;
    tick(8);
    check("ovp_free", {output_overvoltage_guard, hs}, 7'h3F);
    $display("test overvoltage done");
    olow <= 6'h02;
    tick(50);
    olow <= 6'h00;
    tick(8);
    check("scp_short", short_circuit_latch, 0);
    olow <= 6'h02;
    n = 0;
    while (short_circuit_latch !== 1'b1 && n < 140100) begin
      tick(1);
      n++;
    end
    check("scp_time", n >= 139995 && n <= 140010, 1);
    tick(3);
    check("scp_drive", {hs, ls}, 0);
    {olow, want} <= 11'h000;
    tick(8);
    check("scp_clear", short_circuit_latch, 0);
    want <= 5'h1F;
    tick(8);
    check("scp_restart", hs, 6'h3F);
    $display("test short done");
    // Rail two ramps down; step spacing follows the straps
    for (i = 0; i < 2; i++) begin
      {sa, sb} <= i[0] ? 4'h6 : 4'h0;
      want <= 5'h1D;
      tick(8);
      for (int k = 0; k < 2; k++) begin
        v = ramp[15:8];
        n = 0;
        while (ramp[15:8] === v && n < 5000) begin
          tick(1);
          n++;
        end
      end
      check("ramp_step", n, sixrs_pkg::RAMP_US[i[0] ? 5 : 0] * sixrs_pkg::CLK_MHZ / sixrs_pkg::RAMP_STEPS);
    end
    $display("test ramp done");
    finish_test();
  end
endmodule : test_sixrs_supervisor
